// ==== logic/cmp_pkg.sv ====
// Purpose: Shared constants and carrier types for the CAN mode and protection block.
// Assumes: 40 MHz core clock; APB register access with 32-bit words.
// Notes: Register offsets are byte addresses; each register sits in the low bits of its word.
//
// Summary of operation
// - Error counters are read-only; writes to them change nothing.
// - Configuration registers accept writes only while the soft-reset bit is set.
// - Transmit output held recessive in sleep, soft reset and power-down.
// - CPU stop gives power-down; else the sleep-request and soft-reset bits select the mode.
// - Sleep and soft reset stop core clocks except register access; power-down stops all.
// - Wake-up interrupt raised only when sleep-ack and wake enable are both one.
// - Sleep request waits for queued transmits and current reception; idle sleeps at once.
// - Sleep-ack flag is set throughout sleep; software polls it as handshake.
// - Bus-off recovery count pauses in sleep and resumes after wake-up.
// - In sleep, rx-full and tx-empty flags stay usable; no copy or abort.
// - Sleep ends on bus activity, sleep request cleared, or soft reset set.
// - Clearing the sleep request is ignored until sleep-ack reads one.
// - After wake-up, wait 11 recessive bits before resynchronising; waking frame is lost.
// - On wake-up, deferred copies, aborts and transmissions run; buffers keep old messages.
// - Setting soft reset halts transmission and reception at once; registers stay accessible.
// - CPU stop enters power-down: abort activity, recessive output, refuse register access.
// - Bus activity in power-down wakes the chip; no response until resynchronised.
// - In CPU wait, enabled transmit, receive or error interrupts wake the CPU.
// - Wake filter bit low-pass filters the receive input during sleep.
// - A one-bit-time timestamp pulse follows end-of-frame of every valid frame.
// - Timer-link enable routes the timestamp pulse to capture timer channel 0.
// - Status flags clear only by writing one, and stay set while their cause persists.

package cmp_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_MODULE_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_MODULE_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFS_BUS_TIMING_0 = 8'h08;
  localparam logic [7:0] OFS_BUS_TIMING_1 = 8'h0C;
  localparam logic [7:0] OFS_RX_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_TX_FLAGS = 8'h18;
  localparam logic [7:0] OFS_FILTER_CONTROL = 8'h1C;
  localparam logic [7:0] OFS_RX_ERR_COUNT = 8'h20;
  localparam logic [7:0] OFS_TX_ERR_COUNT = 8'h24;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h28;
  localparam logic [7:0] OFS_ACCEPT_BASE = 8'h30;
  localparam logic [7:0] OFS_MASK_BASE = 8'h40;

  // Field positions.
  localparam int BIT_SLEEP_REQUEST = 0;
  localparam int BIT_SLEEP_ACK = 1;
  localparam int BIT_SOFT_RESET = 2;
  localparam int BIT_TS_LINK_EN = 3;
  localparam int BIT_WAKE_FILTER = 0;
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_RX_FULL = 0;
  localparam int BIT_WAKE_FLAG = 7;
  localparam int BIT_WAKE_IRQ_EN = 7;

  // Reset values.
  localparam logic RST_SOFT_RESET = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_TX_EMPTY = 3'h7;

  // Timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_FILTER_NS = 2000;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESYNC_RECESSIVE_BITS = 11;

  typedef enum logic [2:0] {
    CMP_NORMAL = 3'b000,
    CMP_SLEEP = 3'b001,
    CMP_SOFT_RESET = 3'b010,
    CMP_POWER_DOWN = 3'b011,
    CMP_RESYNC = 3'b100
  } cmp_mode_t;

  // Status arriving from the protocol engine, same clock.
  typedef struct packed {
    logic tx_busy;
    logic tx_pending;
    logic rx_busy;
    logic eof_ok;
    logic bit_tick;
    logic bus_off;
    logic rx_full_set;
    logic [2:0] tx_done;
    logic [7:0] rx_err_cnt;
    logic [7:0] tx_err_cnt;
    logic tx_irq;
    logic rx_irq;
    logic err_irq;
    logic tx_bit;
  } cmp_eng_stat_t;

  // Control toward the protocol engine and clock gating.
  typedef struct packed {
    logic core_clk_en;
    logic reg_clk_en;
    logic halt;
    logic busoff_count_en;
    logic deferred_en;
    logic resync;
    logic [2:0] tx_queue;
  } cmp_eng_ctl_t;

  // Locked configuration handed to the engine.
  typedef struct packed {
    logic clk_src;
    logic [7:0] bus_timing_0;
    logic [7:0] bus_timing_1;
    logic [7:0] filter_control;
    logic [3:0][7:0] accept;
    logic [3:0][7:0] mask;
  } cmp_cfg_t;

endpackage : cmp_pkg

// ==== logic/cmp_rx_cond.sv ====
// Purpose: Receive line synchroniser with an optional wake-up low-pass filter.
// Assumes: The receive pin is asynchronous to the core clock.
// Notes: Level one is recessive; activity is a one-cycle pulse on an accepted dominant edge.

`timescale 1ns/100ps

module cmp_rx_cond #(
  parameter int FILT_CYC = cmp_pkg::WAKE_FILTER_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_rx_pin,
  input wire logic i_filter_en,
  output logic o_rx_level,
  output logic o_activity
);

  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(FILT_CYC - 1);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic [CW-1:0] stable_q;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
    end else begin
      sync1_q <= i_rx_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Short glitches never reach the wake logic while filtering is on.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stable_q <= '0;
      o_rx_level <= 1'b1;
      o_activity <= 1'b0;
    end else begin
      o_activity <= 1'b0;
      if (sync2_q != sync3_q || sync3_q == o_rx_level) begin
        stable_q <= '0;
      end else if (!i_filter_en || stable_q == FILT_LAST) begin
        stable_q <= '0;
        o_rx_level <= sync3_q;
        o_activity <= ~sync3_q;
      end else begin
        stable_q <= stable_q + CW'(1);
      end
    end
  end

endmodule : cmp_rx_cond

// ==== logic/cmp_mode_ctrl.sv ====
// Purpose: Mode, wake-up and protection control with its APB register file.
// Assumes: Protocol engine on the same clock; receive pin asynchronous.
// Notes: Registers answer one cycle into the access phase; power-down refuses every access.
//
// The APB register port and the placing of the registers are this design's own decisions.

`timescale 1ns/100ps

module cmp_mode_ctrl #(
  parameter int FILT_CYC = cmp_pkg::WAKE_FILTER_CYC,
  parameter int RESYNC_BITS = cmp_pkg::RESYNC_RECESSIVE_BITS
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_cpu_stop,
  input wire logic i_cpu_wait,
  input wire logic i_rx_pin,
  input wire cmp_pkg::cmp_eng_stat_t i_eng,
  output cmp_pkg::cmp_eng_ctl_t o_eng,
  output cmp_pkg::cmp_cfg_t o_cfg,
  output logic o_can_tx,
  output logic o_wake_irq,
  output logic o_chip_wake,
  output logic o_cpu_wake,
  output logic o_timestamp,
  output logic o_timer_ch0
);

  localparam int RW = $clog2(RESYNC_BITS + 1);
  localparam logic [RW-1:0] RESYNC_LAST = RW'(RESYNC_BITS - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  cmp_pkg::cmp_mode_t mode_q;
  cmp_pkg::cmp_mode_t mode_d;
  logic sleep_req_q;
  logic soft_reset_q;
  logic ts_link_q;
  logic wake_filter_q;
  logic wake_en_q;
  logic wake_flag_q;
  logic rx_full_q;
  logic [2:0] tx_empty_q;
  logic [RW-1:0] recessive_q;
  logic ts_armed_q;
  logic rx_level;
  logic activity;
  logic sleep_ack;
  logic idle;
  logic low_power;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] wbyte;

  assign sleep_ack = (mode_q == cmp_pkg::CMP_SLEEP);
  assign idle = !i_eng.tx_busy && !i_eng.tx_pending && !i_eng.rx_busy;
  assign low_power = (mode_d == cmp_pkg::CMP_SLEEP) || (mode_d == cmp_pkg::CMP_SOFT_RESET) ||
                     (mode_d == cmp_pkg::CMP_POWER_DOWN);
  assign wbyte = i_pwdata[7:0];

  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      cmp_pkg::OFS_MODULE_CONTROL_0, cmp_pkg::OFS_MODULE_CONTROL_1, cmp_pkg::OFS_BUS_TIMING_0,
      cmp_pkg::OFS_BUS_TIMING_1, cmp_pkg::OFS_RX_FLAGS, cmp_pkg::OFS_IRQ_ENABLE,
      cmp_pkg::OFS_TX_FLAGS, cmp_pkg::OFS_FILTER_CONTROL, cmp_pkg::OFS_RX_ERR_COUNT,
      cmp_pkg::OFS_TX_ERR_COUNT, cmp_pkg::OFS_MODE_STATUS: hit = 1'b1;
      default: hit = (a[7:4] == cmp_pkg::OFS_ACCEPT_BASE[7:4] || a[7:4] == cmp_pkg::OFS_MASK_BASE[7:4]) &&
                     (a[1:0] == 2'h0);
    endcase
    return hit;
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////////
  // Receive line conditioning.

  cmp_rx_cond #(
    .FILT_CYC(FILT_CYC)
  ) u_rx_cond (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_rx_pin(i_rx_pin),
    .i_filter_en(wake_filter_q && sleep_ack),
    .o_rx_level(rx_level),
    .o_activity(activity)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode selection.

  always_comb begin
    mode_d = mode_q;
    if (i_cpu_stop) begin
      mode_d = cmp_pkg::CMP_POWER_DOWN;
    end else begin
      unique case (mode_q)
        cmp_pkg::CMP_NORMAL: begin
          if (soft_reset_q) begin
            mode_d = cmp_pkg::CMP_SOFT_RESET;
          end else if (sleep_req_q && idle) begin
            mode_d = cmp_pkg::CMP_SLEEP;
          end
        end
        cmp_pkg::CMP_SLEEP: begin
          if (soft_reset_q) begin
            mode_d = cmp_pkg::CMP_SOFT_RESET;
          end else if (activity || !sleep_req_q) begin
            mode_d = cmp_pkg::CMP_RESYNC;
          end
        end
        cmp_pkg::CMP_SOFT_RESET: begin
          if (!soft_reset_q) begin
            mode_d = cmp_pkg::CMP_RESYNC;
          end
        end
        cmp_pkg::CMP_POWER_DOWN: begin
          mode_d = cmp_pkg::CMP_RESYNC;
        end
        cmp_pkg::CMP_RESYNC: begin
          if (soft_reset_q) begin
            mode_d = cmp_pkg::CMP_SOFT_RESET;
          end else if (i_eng.bit_tick && rx_level && recessive_q == RESYNC_LAST) begin
            mode_d = cmp_pkg::CMP_NORMAL;
          end
        end
        default: mode_d = cmp_pkg::CMP_SOFT_RESET;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= cmp_pkg::CMP_SOFT_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // A dominant bit restarts the count, so the frame that woke the block is skipped.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      recessive_q <= '0;
    end else if (mode_q != cmp_pkg::CMP_RESYNC) begin
      recessive_q <= '0;
    end else if (i_eng.bit_tick) begin
      if (!rx_level || recessive_q == RESYNC_LAST) begin
        recessive_q <= '0;
      end else begin
        recessive_q <= recessive_q + RW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Engine control, clock gating and transmit pin.

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_eng <= '0;
      o_can_tx <= 1'b1;
    end else begin
      o_eng.core_clk_en <= !low_power;
      o_eng.reg_clk_en <= (mode_d != cmp_pkg::CMP_POWER_DOWN);
      o_eng.halt <= (mode_d == cmp_pkg::CMP_SOFT_RESET) || (mode_d == cmp_pkg::CMP_POWER_DOWN);
      o_eng.busoff_count_en <= i_eng.bus_off && !low_power;
      o_eng.deferred_en <= (mode_d == cmp_pkg::CMP_NORMAL);
      o_eng.resync <= (mode_d == cmp_pkg::CMP_RESYNC);
      o_eng.tx_queue <= ~tx_empty_q;
      o_can_tx <= low_power ? 1'b1 : i_eng.tx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up and CPU wake.

  // Set wins over a simultaneous clear; the flag sets only in sleep, so the interrupt outlives the wake.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_flag_q <= 1'b0;
    end else if (activity && sleep_ack && wake_en_q) begin
      wake_flag_q <= 1'b1;
    end else if (wr_en && i_paddr == cmp_pkg::OFS_RX_FLAGS && wbyte[cmp_pkg::BIT_WAKE_FLAG]) begin
      wake_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wake_irq <= 1'b0;
      o_chip_wake <= 1'b0;
      o_cpu_wake <= 1'b0;
    end else begin
      o_wake_irq <= wake_flag_q && wake_en_q;
      o_chip_wake <= activity && (mode_q == cmp_pkg::CMP_POWER_DOWN);
      o_cpu_wake <= i_cpu_wait && (i_eng.tx_irq || i_eng.rx_irq || i_eng.err_irq);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timestamp pulse, aligned to bit ticks so it lasts exactly one bit time.

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ts_armed_q <= 1'b0;
      o_timestamp <= 1'b0;
      o_timer_ch0 <= 1'b0;
    end else begin
      if (i_eng.eof_ok) begin
        ts_armed_q <= 1'b1;
      end else if (i_eng.bit_tick) begin
        ts_armed_q <= 1'b0;
      end
      if (i_eng.bit_tick) begin
        o_timestamp <= ts_armed_q;
        o_timer_ch0 <= ts_armed_q && ts_link_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, refused during power-down.

  assign addr_ok = is_mapped(i_paddr) && (mode_q != cmp_pkg::CMP_POWER_DOWN);
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && addr_ok;
  assign rd_en = i_psel && i_penable && !o_pready && !i_pwrite;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en && addr_ok) begin
      o_prdata <= 32'h0000_0000;
      unique case (i_paddr)
        cmp_pkg::OFS_MODULE_CONTROL_0: begin
          o_prdata[cmp_pkg::BIT_SLEEP_REQUEST] <= sleep_req_q;
          o_prdata[cmp_pkg::BIT_SLEEP_ACK] <= sleep_ack;
          o_prdata[cmp_pkg::BIT_SOFT_RESET] <= soft_reset_q;
          o_prdata[cmp_pkg::BIT_TS_LINK_EN] <= ts_link_q;
        end
        cmp_pkg::OFS_MODULE_CONTROL_1: begin
          o_prdata[cmp_pkg::BIT_WAKE_FILTER] <= wake_filter_q;
          o_prdata[cmp_pkg::BIT_CLK_SRC] <= o_cfg.clk_src;
        end
        cmp_pkg::OFS_BUS_TIMING_0: o_prdata[7:0] <= o_cfg.bus_timing_0;
        cmp_pkg::OFS_BUS_TIMING_1: o_prdata[7:0] <= o_cfg.bus_timing_1;
        cmp_pkg::OFS_RX_FLAGS: begin
          o_prdata[cmp_pkg::BIT_RX_FULL] <= rx_full_q;
          o_prdata[cmp_pkg::BIT_WAKE_FLAG] <= wake_flag_q;
        end
        cmp_pkg::OFS_IRQ_ENABLE: o_prdata[cmp_pkg::BIT_WAKE_IRQ_EN] <= wake_en_q;
        cmp_pkg::OFS_TX_FLAGS: o_prdata[2:0] <= tx_empty_q;
        cmp_pkg::OFS_FILTER_CONTROL: o_prdata[7:0] <= o_cfg.filter_control;
        cmp_pkg::OFS_RX_ERR_COUNT: o_prdata[7:0] <= i_eng.rx_err_cnt;
        cmp_pkg::OFS_TX_ERR_COUNT: o_prdata[7:0] <= i_eng.tx_err_cnt;
        cmp_pkg::OFS_MODE_STATUS: o_prdata[2:0] <= mode_q;
        default: begin
          if (i_paddr[7:4] == cmp_pkg::OFS_ACCEPT_BASE[7:4]) begin
            o_prdata[7:0] <= o_cfg.accept[i_paddr[3:2]];
          end else begin
            o_prdata[7:0] <= o_cfg.mask[i_paddr[3:2]];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Module control 0.

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_req_q <= 1'b0;
      soft_reset_q <= cmp_pkg::RST_SOFT_RESET;
      ts_link_q <= 1'b0;
    end else if (wr_en && i_paddr == cmp_pkg::OFS_MODULE_CONTROL_0) begin
      soft_reset_q <= wbyte[cmp_pkg::BIT_SOFT_RESET];
      ts_link_q <= wbyte[cmp_pkg::BIT_TS_LINK_EN];
      if (wbyte[cmp_pkg::BIT_SLEEP_REQUEST] || !sleep_req_q || sleep_ack) begin
        sleep_req_q <= wbyte[cmp_pkg::BIT_SLEEP_REQUEST];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Locked configuration: written only while soft reset holds the block.

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg <= '0;
      wake_filter_q <= 1'b0;
    end else if (wr_en && soft_reset_q) begin
      unique case (i_paddr)
        cmp_pkg::OFS_MODULE_CONTROL_1: begin
          wake_filter_q <= wbyte[cmp_pkg::BIT_WAKE_FILTER];
          o_cfg.clk_src <= wbyte[cmp_pkg::BIT_CLK_SRC];
        end
        cmp_pkg::OFS_BUS_TIMING_0: o_cfg.bus_timing_0 <= wbyte;
        cmp_pkg::OFS_BUS_TIMING_1: o_cfg.bus_timing_1 <= wbyte;
        cmp_pkg::OFS_FILTER_CONTROL: o_cfg.filter_control <= wbyte;
        default: begin
          if (i_paddr[7:4] == cmp_pkg::OFS_ACCEPT_BASE[7:4]) begin
            o_cfg.accept[i_paddr[3:2]] <= wbyte;
          end else if (i_paddr[7:4] == cmp_pkg::OFS_MASK_BASE[7:4]) begin
            o_cfg.mask[i_paddr[3:2]] <= wbyte;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enable and software-cleared flags. The error counters have no write path.

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_en_q <= 1'b0;
    end else if (wr_en && i_paddr == cmp_pkg::OFS_IRQ_ENABLE) begin
      wake_en_q <= wbyte[cmp_pkg::BIT_WAKE_IRQ_EN];
    end
  end

  // Flags stay writable in sleep so buffers can be drained and reloaded.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_full_q <= 1'b0;
    end else if (i_eng.rx_full_set) begin
      rx_full_q <= 1'b1;
    end else if (wr_en && i_paddr == cmp_pkg::OFS_RX_FLAGS && wbyte[cmp_pkg::BIT_RX_FULL]) begin
      rx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_empty_q <= cmp_pkg::RST_TX_EMPTY;
    end else if (wr_en && i_paddr == cmp_pkg::OFS_TX_FLAGS) begin
      tx_empty_q <= (tx_empty_q & ~wbyte[2:0]) | i_eng.tx_done;
    end else begin
      tx_empty_q <= tx_empty_q | i_eng.tx_done;
    end
  end

endmodule : cmp_mode_ctrl

// ==== test/cmp_mode_sva.sv ====
// Purpose: Port-level assertions for the CAN mode and protection block.
// Assumes: One clock domain; the bus model gives one bit tick every 8 cycles.
// Notes: Bound to every instance of cmp_mode_ctrl.
`timescale 1ns/100ps
module cmp_mode_sva (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_cpu_stop,
  input wire logic i_cpu_wait,
  input wire cmp_pkg::cmp_eng_stat_t i_eng,
  input wire cmp_pkg::cmp_eng_ctl_t o_eng,
  input wire logic o_can_tx,
  input wire logic o_wake_irq,
  input wire logic o_chip_wake,
  input wire logic o_cpu_wake,
  input wire logic o_timestamp,
  input wire logic o_timer_ch0
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  // Three stop samples: the answer at the last one was prepared in power-down.
  sequence s_pd;
    i_cpu_stop ##1 i_cpu_stop ##1 i_cpu_stop;
  endsequence
  sequence s_ts_wait;
    o_timestamp && !i_eng.bit_tick;
  endsequence
  a_stop_recessive: assert property (i_cpu_stop |=> o_can_tx)
    else $error("transmit not recessive in stop");
  a_pd_refused: assert property (s_pd ##0 o_pready |-> o_pslverr)
    else $error("access answered in power-down");
  a_wake_gate: assert property ($rose(o_wake_irq) |-> $past(!o_eng.core_clk_en, 2))
    else $error("wake interrupt outside sleep");
  a_cpu_wake: assert property (o_cpu_wake == $past(i_cpu_wait && (i_eng.tx_irq || i_eng.rx_irq || i_eng.err_irq)))
    else $error("cpu wake does not follow wait and interrupts");
  a_chip_wake: assert property (o_chip_wake |-> $past(i_cpu_stop, 2))
    else $error("chip wake outside power-down");
  a_ts_start: assert property (i_eng.eof_ok && o_eng.core_clk_en |-> ##[1:12] o_timestamp)
    else $error("no timestamp after frame end");
  a_ts_hold: assert property (s_ts_wait |=> o_timestamp)
    else $error("timestamp shorter than a bit");
  a_ts_drop: assert property (o_timestamp && i_eng.bit_tick |=> !o_timestamp)
    else $error("timestamp longer than a bit");
  a_ts_link: assert property (o_timer_ch0 |-> o_timestamp)
    else $error("timer channel pulse without timestamp");
endmodule : cmp_mode_sva
bind cmp_mode_ctrl cmp_mode_sva u_sva (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_cpu_stop(i_cpu_stop), .i_cpu_wait(i_cpu_wait), .i_eng(i_eng), .o_eng(o_eng),
  .o_can_tx(o_can_tx), .o_wake_irq(o_wake_irq), .o_chip_wake(o_chip_wake), .o_cpu_wake(o_cpu_wake),
  .o_timestamp(o_timestamp), .o_timer_ch0(o_timer_ch0));

// ==== test/cmp_bus_model.sv ====
// Purpose: CAN bus and protocol engine stand-in for the mode block.
// Assumes: Bit time of 8 core cycles.
// Notes: Error counts are fixed so read-only checks have known values.
`timescale 1ns/100ps
module cmp_bus_model (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_can_tx,
  input wire logic i_dominant,
  input wire logic i_busy,
  input wire logic i_frame_end,
  input wire logic i_irq,
  output logic o_rx_pin,
  output cmp_pkg::cmp_eng_stat_t o_eng
);
  logic [2:0] tq_q;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tq_q <= 3'h0;
    end else begin
      tq_q <= tq_q + 3'h1;
    end
  end
  // Wired-and bus: a dominant level from either node wins.
  assign o_rx_pin = i_can_tx & ~i_dominant;
  always_comb begin
    o_eng = '0;
    o_eng.bit_tick = (tq_q == 3'h7);
    o_eng.tx_busy = i_busy;
    o_eng.eof_ok = i_frame_end;
    o_eng.rx_err_cnt = 8'h12;
    o_eng.tx_err_cnt = 8'h34;
    o_eng.rx_irq = i_irq;
    o_eng.tx_bit = 1'b1;
  end
endmodule : cmp_bus_model

// ==== test/tb.sv ====
// Purpose: Self-checking bench for cmp_mode_ctrl.
// Assumes: Bus model gives an 8-cycle bit time.
// Notes: Wake filter shortened to 4 cycles to keep the run short.
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic r;} cmp_row_t;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic stop = 1'b0, cwait = 1'b0, dom = 1'b0, busy = 1'b0, fend = 1'b0, irq = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, can_tx, chip_wake, cpu_wake, ts, ch0, rx_pin, er, wake_irq;
  logic [31:0] prdata, rd;
  cmp_pkg::cmp_eng_stat_t eng;
  cmp_pkg::cmp_eng_ctl_t ectl;
  cmp_pkg::cmp_cfg_t cfg;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  // The unmapped row expects the previous read data to stay on the bus.
  cmp_row_t rows [9] = '{'{8'h08, 8'hA5, 8'hA5, 1'b0}, '{8'h0C, 8'h5A, 8'h5A, 1'b0}, '{8'h1C, 8'h3C, 8'h3C, 1'b0},
    '{8'h3C, 8'h81, 8'h81, 1'b0}, '{8'h4C, 8'h7E, 8'h7E, 1'b0}, '{8'h04, 8'h01, 8'h01, 1'b0},
    '{8'h20, 8'hFF, 8'h12, 1'b0}, '{8'h24, 8'hFF, 8'h34, 1'b0}, '{8'h2C, 8'h55, 8'h34, 1'b1}};
  always #12.5 clk = ~clk;
  cmp_bus_model bus (.i_core_clk(clk), .i_sys_rst(rst), .i_can_tx(can_tx), .i_dominant(dom), .i_busy(busy),
    .i_frame_end(fend), .i_irq(irq), .o_rx_pin(rx_pin), .o_eng(eng));
  cmp_mode_ctrl #(.FILT_CYC(4), .RESYNC_BITS(11)) dut (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_cpu_stop(stop), .i_cpu_wait(cwait), .i_rx_pin(rx_pin),
    .i_eng(eng), .o_eng(ectl), .o_cfg(cfg), .o_can_tx(can_tx), .o_wake_irq(wake_irq), .o_chip_wake(chip_wake),
    .o_cpu_wake(cpu_wake), .o_timestamp(ts), .o_timer_ch0(ch0));
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk_reg(n, 32'h2);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, e);
  endtask : rchk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, {24'h0, rows[i].d});
      chk_bit(er, rows[i].r);
      rchk(rows[i].a, {24'h0, rows[i].e});
      chk_bit(er, rows[i].r);
    end
    rchk(8'h28, 32'h2);
    rchk(8'h00, 32'h4);
    rchk(8'h18, 32'h7);
    apb(1'b1, 8'h00, 32'h0);
    repeat (110) @(posedge clk);
    rchk(8'h28, 32'h0);
    apb(1'b1, 8'h08, 32'h11);
    rchk(8'h08, 32'hA5);
    chk_reg({24'h0, cfg.bus_timing_0}, 32'hA5);
    busy <= 1'b1;
    apb(1'b1, 8'h00, 32'h1);
    rchk(8'h28, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    rchk(8'h00, 32'h1);
    busy <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(8'h00, 32'h3);
    chk_bit(ectl.core_clk_en, 1'b0);
    chk_bit(can_tx, 1'b1);
    apb(1'b1, 8'h14, 32'h80);
    dom <= 1'b1;
    repeat (20) @(posedge clk);
    dom <= 1'b0;
    rchk(8'h10, 32'h80);
    chk_bit(wake_irq, 1'b1);
    rchk(8'h28, 32'h4);
    apb(1'b1, 8'h00, 32'h4);
    rchk(8'h28, 32'h2);
    chk_bit(ectl.halt, 1'b1);
    apb(1'b1, 8'h10, 32'h80);
    rchk(8'h10, 32'h0);
    chk_bit(wake_irq, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    repeat (110) @(posedge clk);
    apb(1'b1, 8'h00, 32'h1);
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h00, 32'h0);
    rchk(8'h28, 32'h4);
    repeat (110) @(posedge clk);
    apb(1'b1, 8'h00, 32'h8);
    fend <= 1'b1;
    @(posedge clk);
    fend <= 1'b0;
    for (n = 0; n < 20 && ch0 !== 1'b1; n++) @(posedge clk);
    chk_bit(ch0, 1'b1);
    chk_bit(ts, 1'b1);
    cwait <= 1'b1;
    irq <= 1'b1;
    repeat (2) @(posedge clk);
    chk_bit(cpu_wake, 1'b1);
    cwait <= 1'b0;
    irq <= 1'b0;
    apb(1'b1, 8'h00, 32'h1);
    stop <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, 8'h28, 32'h0);
    chk_bit(er, 1'b1);
    chk_bit(ectl.reg_clk_en, 1'b0);
    chk_bit(can_tx, 1'b1);
    dom <= 1'b1;
    for (n = 0; n < 40 && chip_wake !== 1'b1; n++) @(posedge clk);
    chk_bit(chip_wake, 1'b1);
    dom <= 1'b0;
    stop <= 1'b0;
    end_of_test();
  end
endmodule : tb
